// ### gpio_pin_sync.sv
`timescale 1ns/10ps
`include "gpio_port_regs.svh"

module gpio_pin_sync (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rstn,
	// Pins
	input  wire gpio_port_pkg::pin_vec_t pin_raw,
	output var   gpio_port_pkg::pin_vec_t pin_sync
);
	import gpio_port_pkg::*;

	pin_vec_t stage_one;

	genvar g;
	generate
		for (g = 0; g < `PIN_COUNT; g++) begin : g_sync
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					stage_one[g] <= 1'b0;
					pin_sync[g]  <= 1'b0;
				end else begin
					stage_one[g] <= pin_raw[g]; // [RULE_09]
					pin_sync[g]  <= stage_one[g];
				end
			end
		end
	endgenerate
endmodule

// ### gpio_port.sv
// Operation
// RULE_01 - The port and its control path work only in configuration mode zero or one; irq still follows a flag set before the mode left zero or one.
// RULE_02 - There are four pins, each either plain I/O or given to an alternate function.
// RULE_03 - A pin with no alternate function assigned acts as plain I/O.
// RULE_04 - Host sets each pin's direction first; device drives or releases pins accordingly.
// RULE_05 - Reads return present pin levels; writes drive levels onto output pins.
// RULE_06 - Pin 3 can be chosen by the host as an interrupt input.
// RULE_07 - The pin 3 interrupt fires on rising or falling edge per a stored edge setting.
// RULE_08 - With the edge setting untouched, the pin 3 interrupt uses the rising edge.
// RULE_09 - Inputs are synchronised and each qualifying edge sets a flag held until read.
`timescale 1ns/10ps
`include "gpio_port_regs.svh"

module gpio_port (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rstn,
	// Device configuration mode
	input  wire gpio_port_pkg::config_mode_t config_mode,
	// Register port
	input  wire gpio_port_pkg::addr_t    reg_addr,
	input  wire gpio_port_pkg::data_t    reg_wdata,
	input  wire logic                    reg_write,
	input  wire logic                    reg_read,
	output var   gpio_port_pkg::data_t   reg_rdata,
	// Port pins
	input  wire gpio_port_pkg::pin_vec_t pin_in,
	output var   gpio_port_pkg::pin_vec_t pin_out,
	output var   gpio_port_pkg::pin_vec_t pin_oe,
	// Alternate function hand-off
	output var   gpio_port_pkg::pin_vec_t alt_select,
	// Interrupt
	output logic                         irq
);
	import gpio_port_pkg::*;

	pin_vec_t    pin_dir;
	pin_vec_t    pin_level;
	pin_vec_t    alt_map;
	data_t       ctrl;
	data_t       irq_status;
	data_t       irq_mask;
	pin_vec_t    pin_sync;
	logic        port_enabled;
	logic        wr_ok;
	logic        rd_ok;
	logic        irq_sel;
	logic        fall_edge;
	logic        pin3_prev;
	logic        edge_hit;
	logic        status_read;
	edge_state_e edge_state;
	edge_state_e next_edge_state;
	data_t       next_rdata;

	function automatic logic is_addr(input addr_t a, input addr_t target);
		return a == target;
	endfunction

	assign port_enabled = (config_mode == `MODE_ZERO) || (config_mode == `MODE_ONE); // [RULE_01]
	assign wr_ok        = reg_write && port_enabled; // [RULE_01]
	assign rd_ok        = reg_read && port_enabled;
	assign irq_sel      = ctrl[`CTRL_IRQ_SEL_BIT];
	assign fall_edge    = ctrl[`CTRL_FALL_BIT];
	assign status_read  = rd_ok && is_addr(reg_addr, `REG_IRQ_STATUS);

	gpio_pin_sync u_sync (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.pin_raw  (pin_in),
		.pin_sync (pin_sync)
	);

	// Direction register, all inputs after reset so nothing fights the board
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin_dir <= `DIR_RESET;
		end else if (wr_ok && is_addr(reg_addr, `REG_DIR)) begin
			pin_dir <= reg_wdata[3:0]; // [RULE_04]
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin_level <= `OUT_RESET;
		end else if (wr_ok && is_addr(reg_addr, `REG_OUT)) begin
			pin_level <= reg_wdata[3:0]; // [RULE_05]
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			alt_map <= `ALT_RESET; // [RULE_03]
		end else if (wr_ok && is_addr(reg_addr, `REG_ALT)) begin
			alt_map <= reg_wdata[3:0]; // [RULE_02]
		end
	end

	// Edge bit reset to zero means rising edge
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= `CTRL_RESET; // [RULE_08]
		end else if (wr_ok && is_addr(reg_addr, `REG_CTRL)) begin
			ctrl <= {6'h00, reg_wdata[1:0]}; // [RULE_06]
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_mask <= `MASK_RESET;
		end else if (wr_ok && is_addr(reg_addr, `REG_IRQ_MASK)) begin
			irq_mask <= {7'h00, reg_wdata[0]};
		end
	end

	// Pins leave plain I/O when handed to an alternate function, or for pin 3 when selected as the interrupt input
	genvar g;
	generate
		for (g = 0; g < `PIN_COUNT; g++) begin : g_pin
			logic plain_io;
			if (g == 3) begin : g_irq_pin
				assign plain_io = !alt_map[g] && !irq_sel; // [RULE_06]
			end else begin : g_std_pin
				assign plain_io = !alt_map[g]; // [RULE_03]
			end
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					pin_oe[g]     <= 1'b0;
					pin_out[g]    <= 1'b0;
					alt_select[g] <= 1'b0;
				end else begin
					pin_oe[g]     <= port_enabled && plain_io && pin_dir[g]; // [RULE_04]
					pin_out[g]    <= pin_level[g]; // [RULE_05]
					alt_select[g] <= port_enabled && !plain_io; // [RULE_02]
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin3_prev <= 1'b0;
		end else begin
			pin3_prev <= pin_sync[`IRQ_PIN];
		end
	end

	// Rising unless the stored edge bit selects falling
	assign edge_hit = fall_edge ? (pin3_prev && !pin_sync[`IRQ_PIN])
		: (!pin3_prev && pin_sync[`IRQ_PIN]); // [RULE_07]

	// Arm only after one settled sample, so a select write cannot fake an edge
	always_comb begin
		next_edge_state = edge_state;
		case (edge_state)
			edge_idle: begin
				if (irq_sel && port_enabled) begin
					next_edge_state = edge_armed;
				end
			end
			edge_armed: begin
				if (!(irq_sel && port_enabled)) begin
					next_edge_state = edge_idle;
				end else if (edge_hit) begin
					next_edge_state = edge_seen;
				end
			end
			edge_seen: begin
				if (!(irq_sel && port_enabled)) begin
					next_edge_state = edge_idle;
				end else begin
					next_edge_state = edge_armed;
				end
			end
			default: begin
				next_edge_state = edge_idle;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			edge_state <= edge_idle;
		end else begin
			edge_state <= next_edge_state;
		end
	end

	// Set wins over the clearing read
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_status <= 8'h00;
		end else if (edge_state == edge_armed && edge_hit && irq_sel && port_enabled) begin
			irq_status <= 8'h01; // [RULE_09]
		end else if (status_read) begin
			irq_status <= 8'h00; // [RULE_09]
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		if (!rd_ok) begin
			next_rdata = 8'h00;
		end else if (is_addr(reg_addr, `REG_DIR)) begin
			next_rdata = {4'h0, pin_dir};
		end else if (is_addr(reg_addr, `REG_OUT)) begin
			next_rdata = {4'h0, pin_level};
		end else if (is_addr(reg_addr, `REG_IN)) begin
			next_rdata = {4'h0, pin_sync}; // [RULE_05]
		end else if (is_addr(reg_addr, `REG_ALT)) begin
			next_rdata = {4'h0, alt_map};
		end else if (is_addr(reg_addr, `REG_CTRL)) begin
			next_rdata = ctrl;
		end else if (is_addr(reg_addr, `REG_IRQ_STATUS)) begin
			next_rdata = irq_status;
		end else if (is_addr(reg_addr, `REG_IRQ_MASK)) begin
			next_rdata = irq_mask;
		end else if (is_addr(reg_addr, `REG_MODE)) begin
			next_rdata = {6'h00, config_mode};
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end
endmodule

// ### gpio_port_asserts.sv
`timescale 1ns/10ps
`include "gpio_port_regs.svh"
module gpio_port_asserts (
	// Clock and reset
	input wire logic                        ref_clk,
	input wire logic                        rstn,
	// Mode and register port
	input wire gpio_port_pkg::config_mode_t config_mode,
	input wire gpio_port_pkg::addr_t        reg_addr,
	input wire gpio_port_pkg::data_t        reg_wdata,
	input wire logic                        reg_write,
	input wire logic                        reg_read,
	input wire gpio_port_pkg::data_t        reg_rdata,
	// Pins and interrupt
	input wire gpio_port_pkg::pin_vec_t     pin_in,
	input wire gpio_port_pkg::pin_vec_t     pin_out,
	input wire gpio_port_pkg::pin_vec_t     pin_oe,
	input wire gpio_port_pkg::pin_vec_t     alt_select,
	input wire logic                        irq
);
	import gpio_port_pkg::*;
	wire on = config_mode < 2'h2;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	property p_off; !on |=> pin_oe == 4'h0 && alt_select == 4'h0; endproperty
	a_off: assert property (p_off) else $error("pins live while off");
	property p_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("stray read data");
	property p_mode; reg_read && reg_addr == `REG_MODE && on |=> reg_rdata == {6'h0, $past(config_mode)};
	endproperty
	a_mode: assert property (p_mode) else $error("bad mode readback");
	property p_dir;
		reg_write && reg_addr == `REG_DIR && on ##1 on && !(reg_write && reg_addr == `REG_DIR)
		|=> (pin_oe & ~alt_select) == ($past(reg_wdata[3:0], 2) & ~alt_select);
	endproperty
	a_dir: assert property (p_dir) else $error("direction not applied");
	property p_out;
		reg_write && reg_addr == `REG_OUT && on ##1 on && !(reg_write && reg_addr == `REG_OUT)
		|=> (pin_out & pin_oe) == ($past(reg_wdata[3:0], 2) & pin_oe);
	endproperty
	a_out: assert property (p_out) else $error("level not driven");
	property p_in;
		reg_read && reg_addr == `REG_IN && on && pin_in == $past(pin_in)
		&& pin_in == $past(pin_in, 2) && pin_in == $past(pin_in, 3) |=> reg_rdata == {4'h0, $past(pin_in)};
	endproperty
	a_in: assert property (p_in) else $error("bad pin readback");
	// A mask write one cycle back may drop the line legally
	property p_hold;
		irq && on && $past(on) && !reg_read && !reg_write && !$past(reg_read) && !$past(reg_write)
		|=> irq;
	endproperty
	a_hold: assert property (p_hold) else $error("irq dropped unread");
	property p_refuse; reg_read && !on |=> reg_rdata == 8'h00; endproperty
	a_refuse: assert property (p_refuse) else $error("read served while off");
	c_irq: cover property ($rose(irq));
	c_off: cover property (!on && reg_write);
	c_clr: cover property (reg_read && reg_addr == `REG_IRQ_STATUS && irq);
endmodule

// ### gpio_port_pkg.sv
package gpio_port_pkg;
	typedef logic [3:0] pin_vec_t;
	typedef logic [1:0] config_mode_t;
	typedef logic [7:0] data_t;
	typedef logic [3:0] addr_t;
	typedef enum logic [1:0] {
		edge_idle,
		edge_armed,
		edge_seen
	} edge_state_e;
endpackage

// ### gpio_port_regs.svh
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

`define PIN_COUNT        4
`define ADDR_W           4
`define DATA_W           8

`define REG_DIR          4'h0
`define REG_OUT          4'h1
`define REG_IN           4'h2
`define REG_ALT          4'h3
`define REG_CTRL         4'h4
`define REG_IRQ_STATUS   4'h5
`define REG_IRQ_MASK     4'h6
`define REG_MODE         4'h7

`define CTRL_IRQ_SEL_BIT 0
`define CTRL_FALL_BIT    1
`define IRQ_PIN          2'h3

`define MODE_ZERO        2'h0
`define MODE_ONE         2'h1

`define DIR_RESET        4'h0
`define OUT_RESET        4'h0
`define ALT_RESET        4'h0
`define CTRL_RESET       8'h00
`define MASK_RESET       8'h00

`endif

// ### pin_model.sv
`timescale 1ns/10ps
module pin_model (
	// Device side
	input wire gpio_port_pkg::pin_vec_t pin_out,
	input wire gpio_port_pkg::pin_vec_t pin_oe,
	// Board side
	input wire gpio_port_pkg::pin_vec_t ext_drive,
	output     gpio_port_pkg::pin_vec_t pin_lvl
);
	import gpio_port_pkg::*;
	// Board yields wherever the device drives
	assign pin_lvl = (pin_out & pin_oe) | (ext_drive & ~pin_oe);
endmodule

// ### tb_top.sv
`timescale 1ns/10ps
`include "gpio_port_regs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
	$display("FAIL %0t got %h want %h", $time, a, e); end end
module tb_top;
	import gpio_port_pkg::*;
	logic         ref_clk = 1'b0;
	logic         rstn = 1'b0;
	config_mode_t config_mode = 2'h0;
	addr_t        reg_addr = 4'h0;
	data_t        reg_wdata = 8'h00;
	logic         reg_write = 1'b0;
	logic         reg_read = 1'b0;
	data_t        reg_rdata;
	pin_vec_t     pin_in, pin_out, pin_oe, alt_select, d, o;
	pin_vec_t     ext = 4'h0;
	logic         irq;
	int           fails = 0, total_checks = 0, cycles = 0, seed = 6649;
	always #12.5 ref_clk = ~ref_clk;
	gpio_port dut (
		.ref_clk     (ref_clk),
		.rstn        (rstn),
		.config_mode (config_mode),
		.reg_addr    (reg_addr),
		.reg_wdata   (reg_wdata),
		.reg_write   (reg_write),
		.reg_read    (reg_read),
		.reg_rdata   (reg_rdata),
		.pin_in      (pin_in),
		.pin_out     (pin_out),
		.pin_oe      (pin_oe),
		.alt_select  (alt_select),
		.irq         (irq)
	);
	pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext), .pin_lvl(pin_in));
	function automatic pin_vec_t lvl(pin_vec_t dir, pin_vec_t lev, pin_vec_t brd);
		return (lev & dir) | (brd & ~dir);
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(addr_t a, data_t v);
		@(posedge ref_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(addr_t a, data_t e);
		@(posedge ref_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	task automatic edge3(logic v, logic e);
		@(posedge ref_clk);
		ext[3] <= v;
		tick(6);
		`CHK(irq, e)
	endtask
	task automatic finish_test;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Run takes a few hundred cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 4000) begin
			fails++;
			finish_test();
		end
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(`REG_DIR, {4'h0, `DIR_RESET});
		rd(`REG_ALT, {4'h0, `ALT_RESET});
		rd(`REG_CTRL, `CTRL_RESET);
		rd(4'h9, 8'h00);
		wr(`REG_MODE, 8'hFF);
		rd(`REG_MODE, 8'h00);
		for (int i = 0; i < 12; i++) begin
			d = (i == 0) ? 4'hF : pin_vec_t'($random(seed));
			o = pin_vec_t'($random(seed));
			@(posedge ref_clk);
			ext <= pin_vec_t'($random(seed));
			config_mode <= {1'b0, i[0]};
			wr(`REG_DIR, {4'h0, d});
			wr(`REG_OUT, {4'h0, o});
			tick(6);
			`CHK(pin_oe, d)
			`CHK(pin_out, o)
			rd(`REG_IN, {4'h0, lvl(d, o, ext)});
		end
		wr(`REG_ALT, 8'h05);
		tick(3);
		`CHK(alt_select, 4'h5)
		wr(`REG_ALT, 8'h00);
		for (int m = 0; m < 4; m++) begin
			@(posedge ref_clk);
			config_mode <= m[1:0];
			wr(`REG_DIR, data_t'(1 << m));
			tick(3);
			`CHK(pin_oe, (m < 2) ? pin_vec_t'(1 << m) : 4'h0)
			rd(`REG_MODE, (m < 2) ? data_t'(m) : 8'h00);
		end
		@(posedge ref_clk);
		config_mode <= 2'h0;
		ext <= 4'h0;
		rd(`REG_DIR, 8'h02);
		rd(`REG_OUT, {4'h0, o});
		wr(`REG_DIR, 8'h00);
		wr(`REG_IRQ_MASK, 8'h01);
		rd(`REG_IRQ_MASK, 8'h01);
		wr(`REG_CTRL, 8'h01);
		tick(3);
		`CHK({alt_select[3], pin_oe[3]}, 2'b10)
		edge3(1'b1, 1'b1);
		rd(`REG_IRQ_STATUS, 8'h01);
		edge3(1'b0, 1'b0);
		wr(`REG_CTRL, 8'h03);
		edge3(1'b1, 1'b0);
		edge3(1'b0, 1'b1);
		rd(`REG_IRQ_STATUS, 8'h01);
		rd(`REG_IRQ_STATUS, 8'h00);
		wr(`REG_IRQ_MASK, 8'h00);
		edge3(1'b1, 1'b0);
		edge3(1'b0, 1'b0);
		rd(`REG_IRQ_STATUS, 8'h01);
		finish_test();
	end
endmodule
bind gpio_port gpio_port_asserts u_chk (
	.ref_clk     (ref_clk),
	.rstn        (rstn),
	.config_mode (config_mode),
	.reg_addr    (reg_addr),
	.reg_wdata   (reg_wdata),
	.reg_write   (reg_write),
	.reg_read    (reg_read),
	.reg_rdata   (reg_rdata),
	.pin_in      (pin_in),
	.pin_out     (pin_out),
	.pin_oe      (pin_oe),
	.alt_select  (alt_select),
	.irq         (irq)
);
